/* design/event_report_regs.vh */
/*
  Constants for the event reporting block: parameter kinds, mask reset
  values, field widths and timing counts.
  Assumes inclusion by bare name from the design and verification files.
*/
`ifndef EVENT_REPORT_REGS_VH
`define EVENT_REPORT_REGS_VH
// Parameter kinds on the setting port.
`define KIND_MASK      3'h0
`define KIND_DISABLE   3'h1
`define KIND_DELAY     3'h2
`define KIND_AR_SEL    3'h3
`define KIND_AR_START  3'h4
`define KIND_AR_DEAD   3'h5
`define KIND_RECLAIM   3'h6
`define KIND_AR_ENABLE 3'h7
// Event mask reset values.
`define MASK_CH0_GEN_RST  11'h043
`define MASK_CH0_C12_RST  11'h063
`define MASK_CH0_C34_RST  11'h063
`define MASK_CH0_C5T_RST  11'h703
`define MASK_OBJ_RST      11'h753
`define MASK_IN_RST       11'h003
// Mask value limits.
`define MASK_LIM_10 11'h03FF
`define MASK_LIM_11 11'h07FF
`define MASK_LIM_4  11'h000F
// Default cycle selection once reclosing is enabled: b and c initiate.
`define AR_SEL_DEFAULT 15'h0036
// Event slots: channel 0 holds four words of 11 slots, then 11 per channel.
`define SLOTS_CH0   44
`define SLOTS_TOTAL 231
// Special event code for register overflow.
`define CODE_OVERFLOW 6'h33
// Timing: clock rate, millisecond tick, timestamp wrap at 60 s.
`define CLK_HZ       50000000
`define TICK_MS      1
`define CLK_PER_MS   ((`CLK_HZ / 1000) * `TICK_MS)
`define TS_WRAP_MS   16'hEA60
`endif

/* design/event_delay_filter.v */
/*
  Stability filter for one status value: a change is passed on only after
  the new value has stood unchanged for longer than the delay.
  Assumes a one-cycle millisecond tick and a delay chosen from candVal.
*/
`timescale 1ns/1ps
`default_nettype none
module event_delay_filter #(
  parameter W  = 2,
  parameter DW = 16
) (
  // Clock, reset and millisecond tick.
  input  wire          core_clk,
  input  wire          reset,
  input  wire          msTick,
  // Raw value and its delay.
  input  wire [W-1:0]  rawVal,
  input  wire [DW-1:0] delayMs,
  // Filtered value and change strobe.
  output reg  [W-1:0]  candVal,
  output reg  [W-1:0]  stableVal_ff,
  output reg           changePulse_ff
);
  reg [DW:0] cnt_ff;

  // Restart timing on every raw change, commit once stable past the delay.
  always @(posedge core_clk) begin
    changePulse_ff <= 1'b0;
    if (reset) begin
      candVal      <= {W{1'b0}};
      stableVal_ff <= {W{1'b0}};
      cnt_ff       <= {(DW+1){1'b0}};
    end else if (rawVal != candVal) begin
      candVal <= rawVal;
      cnt_ff  <= {(DW+1){1'b0}};
    end else if (candVal != stableVal_ff && msTick) begin
      if (cnt_ff > {1'b0, delayMs}) begin
        stableVal_ff   <= candVal;
        changePulse_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* design/event_mask_reporting.v */
/*
  Event reporting core: codes status changes and reclose events per
  channel, filters status changes, qualifies by mask and, on channels 1 to 17, by disable, time-stamps
  them and queues them for the remote reader. Also holds reclose settings.
  Assumes the serial protocol layer drives the setting and event ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_report_regs.vh"
////////////////////////////////////////////////////////////////////////////
module event_mask_reporting #(
  parameter CLK_PER_MS = `CLK_PER_MS,
  parameter DEPTH      = 100,
  parameter DW         = 16
) (
  // Clock and reset.
  input  wire             core_clk,
  input  wire             reset,
  // Setting port.
  input  wire             paramWrite,
  input  wire             paramRead,
  input  wire [2:0]       paramKind,
  input  wire [4:0]       paramChan,
  input  wire [3:0]       paramIdx,
  input  wire [15:0]      paramData,
  output reg  [15:0]      paramRdData_ff,
  // Object channels 1 to 7.
  input  wire [13:0]      objStatus,
  input  wire [6:0]       openOut,
  input  wire [6:0]       closeOut,
  input  wire [6:0]       objActReq,
  input  wire [6:0]       objBlock,
  input  wire [6:0]       objNoSelect,
  // Input channels 8 to 17.
  input  wire [9:0]       inputLevel,
  input  wire [9:0]       sigOutLevel,
  // Channel 0 events from the reclose sequencer and front panel.
  input  wire [9:0]       ch0GenEvt,
  input  wire [30:0]      ch0CycEvt,
  // Event read port.
  input  wire             evtRead,
  output reg              evtValid_ff,
  output reg  [15:0]      evtTime_ff,
  output reg  [4:0]       evtChan_ff,
  output reg  [5:0]       evtCode_ff,
  // Reclose configuration.
  output reg              arEnable_ff,
  output wire [14:0]      arCycleInit,
  output wire [5*2*DW-1:0] arStartFlat,
  output wire [5*DW-1:0]  arDeadFlat,
  output reg  [DW-1:0]    reclaim_ff
);
  localparam NS = `SLOTS_TOTAL;
  integer i;

  // Limit of a mask word, indexed 0..3 for channel 0 then one per channel.
  function [10:0] maskLimit;
    input [4:0] mi;
    begin
      if (mi < 5'd3) maskLimit = `MASK_LIM_10;
      else if (mi < 5'd11) maskLimit = `MASK_LIM_11;
      else maskLimit = `MASK_LIM_4;
    end
  endfunction

  // Mask word index for a channel and word number.
  function [4:0] maskIndex;
    input [4:0] ch;
    input [3:0] ix;
    begin
      maskIndex = (ch == 5'd0) ? {3'h0, ix[1:0]} : ch + 5'd3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick and timestamp.
  reg [31:0] div_ff;
  reg        msTick_ff;
  reg [15:0] timeMs_ff;
  always @(posedge core_clk) begin
    if (reset) begin
      div_ff    <= 32'h0000_0000;
      msTick_ff <= 1'b0;
      timeMs_ff <= 16'h0000;
    end else begin
      msTick_ff <= (div_ff == CLK_PER_MS - 1);
      div_ff    <= (div_ff == CLK_PER_MS - 1) ? 32'h0000_0000 : div_ff + 32'h0000_0001;
      if (msTick_ff) begin
        timeMs_ff <= (timeMs_ff == `TS_WRAP_MS - 1'h1) ? 16'h0000 : timeMs_ff + 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Setting registers.
  reg [10:0]   mask_ff [0:20];
  reg [17:1]   dis_ff;
  reg [DW-1:0] objDly_ff [0:27];
  reg [DW-1:0] inDly_ff [0:19];
  reg [14:0]   arSel_ff;
  reg [DW-1:0] arStart_ff [0:9];
  reg [DW-1:0] arDead_ff [0:4];
  reg          arOnEvt_ff;
  reg          arOffEvt_ff;
  wire [4:0]   wIdx = maskIndex(paramChan, paramIdx);

  // Writes clip masks to their legal width; enable edges raise events.
  always @(posedge core_clk) begin
    arOnEvt_ff  <= 1'b0;
    arOffEvt_ff <= 1'b0;
    if (reset) begin
      mask_ff[0] <= `MASK_CH0_GEN_RST;
      mask_ff[1] <= `MASK_CH0_C12_RST;
      mask_ff[2] <= `MASK_CH0_C34_RST;
      mask_ff[3] <= `MASK_CH0_C5T_RST;
      for (i = 4; i < 21; i = i + 1) begin
        mask_ff[i] <= (i < 11) ? `MASK_OBJ_RST : `MASK_IN_RST;
      end
      for (i = 0; i < 28; i = i + 1) begin
        objDly_ff[i] <= {DW{1'b0}};
      end
      for (i = 0; i < 20; i = i + 1) begin
        inDly_ff[i] <= {DW{1'b0}};
      end
      for (i = 0; i < 10; i = i + 1) begin
        arStart_ff[i] <= {DW{1'b0}};
      end
      for (i = 0; i < 5; i = i + 1) begin
        arDead_ff[i] <= {DW{1'b0}};
      end
      dis_ff      <= 17'h0_0000;
      arSel_ff    <= `AR_SEL_DEFAULT;
      arEnable_ff <= 1'b0;
      reclaim_ff  <= {DW{1'b0}};
    end else if (paramWrite) begin
      case (paramKind)
        `KIND_MASK: begin
          mask_ff[wIdx] <= paramData[10:0] & maskLimit(wIdx);
        end
        `KIND_DISABLE: begin
          if (paramChan != 5'd0) dis_ff[paramChan] <= (paramData != 16'h0000);
        end
        `KIND_DELAY: begin
          if (paramChan < 5'd8) begin
            objDly_ff[(paramChan - 5'd1) * 4 + paramIdx[1:0]] <= paramData;
          end else begin
            inDly_ff[(paramChan - 5'd8) * 2 + paramIdx[0]] <= paramData;
          end
        end
        `KIND_AR_SEL: begin
          arSel_ff[paramChan[2:0] * 3 + paramIdx[1:0]] <= paramData[0];
        end
        `KIND_AR_START: begin
          arStart_ff[paramChan[2:0] * 2 + paramIdx[0]] <= paramData;
        end
        `KIND_AR_DEAD: begin
          arDead_ff[paramChan[2:0]] <= paramData;
        end
        `KIND_RECLAIM: begin
          reclaim_ff <= paramData;
        end
        `KIND_AR_ENABLE: begin
          arEnable_ff <= paramData[0];
          arOnEvt_ff  <= paramData[0] & ~arEnable_ff;
          arOffEvt_ff <= ~paramData[0] & arEnable_ff;
        end
        default: begin
          dis_ff <= dis_ff;
        end
      endcase
    end
  end

  // Cycles are only initiated while reclosing is enabled.
  assign arCycleInit = arEnable_ff ? arSel_ff : 15'h0000;
  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gStart
      assign arStartFlat[g*DW +: DW] = arStart_ff[g];
    end
    for (g = 0; g < 5; g = g + 1) begin : gDead
      assign arDeadFlat[g*DW +: DW] = arDead_ff[g];
    end
  endgenerate

  // Setting read-back.
  always @(posedge core_clk) begin
    if (reset) begin
      paramRdData_ff <= 16'h0000;
    end else if (paramRead) begin
      case (paramKind)
        `KIND_MASK:      paramRdData_ff <= {5'h00, mask_ff[wIdx]};
        `KIND_DISABLE:   paramRdData_ff <= {15'h0000, (paramChan != 5'd0) & dis_ff[paramChan]};
        `KIND_AR_SEL:    paramRdData_ff <= {15'h0000, arSel_ff[paramChan[2:0]*3 + paramIdx[1:0]]};
        `KIND_AR_DEAD:   paramRdData_ff <= arDead_ff[paramChan[2:0]];
        `KIND_RECLAIM:   paramRdData_ff <= reclaim_ff;
        `KIND_AR_ENABLE: paramRdData_ff <= {15'h0000, arEnable_ff};
        default:         paramRdData_ff <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stability filters for object and input channels.
  wire [13:0] objCand;
  wire [13:0] objStable;
  wire [6:0]  objChg;
  wire [9:0]  inCand;
  wire [9:0]  inStable;
  wire [9:0]  inChg;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gObj
      // Delay index: open 0, closed 1, undefined 11 is 2, undefined 00 is 3.
      wire [1:0] c = objCand[2*g +: 2];
      wire [1:0] sel = (c == 2'b10) ? 2'd0 : (c == 2'b01) ? 2'd1 : (c == 2'b11) ? 2'd2 : 2'd3;
      event_delay_filter #(.W(2), .DW(DW)) uObj (
        .core_clk       (core_clk),
        .reset          (reset),
        .msTick         (msTick_ff),
        .rawVal         (objStatus[2*g +: 2]),
        .delayMs        (objDly_ff[g*4 + sel]),
        .candVal        (objCand[2*g +: 2]),
        .stableVal_ff   (objStable[2*g +: 2]),
        .changePulse_ff (objChg[g])
      );
    end
    for (g = 0; g < 10; g = g + 1) begin : gIn
      event_delay_filter #(.W(1), .DW(DW)) uIn (
        .core_clk       (core_clk),
        .reset          (reset),
        .msTick         (msTick_ff),
        .rawVal         (inputLevel[g]),
        .delayMs        (inDly_ff[g*2 + {1'b0, ~inCand[g]}]),
        .candVal        (inCand[g]),
        .stableVal_ff   (inStable[g]),
        .changePulse_ff (inChg[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Edge detection and failed-operation check.
  reg [6:0]  openPrev_ff;
  reg [6:0]  closePrev_ff;
  reg [9:0]  sigPrev_ff;
  reg [13:0] statAtPulse_ff;
  wire [6:0] pulseOn  = openOut | closeOut;
  wire [6:0] pulseWas = openPrev_ff | closePrev_ff;
  always @(posedge core_clk) begin
    if (reset) begin
      openPrev_ff    <= 7'h00;
      closePrev_ff   <= 7'h00;
      sigPrev_ff     <= 10'h000;
      statAtPulse_ff <= 14'h0000;
    end else begin
      openPrev_ff  <= openOut;
      closePrev_ff <= closeOut;
      sigPrev_ff   <= sigOutLevel;
      for (i = 0; i < 7; i = i + 1) begin
        if (pulseOn[i] & ~pulseWas[i]) statAtPulse_ff[2*i +: 2] <= objStatus[2*i +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Raw event slots, one bit per channel and code.
  reg [NS-1:0] raw;
  always @* begin
    raw = {NS{1'b0}};
    raw[9:0]   = ch0GenEvt | {4'h0, arOffEvt_ff, arOnEvt_ff, 4'h0};
    raw[20:11] = ch0CycEvt[9:0];
    raw[31:22] = ch0CycEvt[19:10];
    raw[43:33] = ch0CycEvt[30:20];
    for (i = 0; i < 7; i = i + 1) begin
      raw[44 + 11*i + 0]  = objChg[i] & (objStable[2*i +: 2] == 2'b10);
      raw[44 + 11*i + 1]  = objChg[i] & (objStable[2*i +: 2] == 2'b01);
      raw[44 + 11*i + 2]  = objChg[i] & (objStable[2*i +: 2] == 2'b11);
      raw[44 + 11*i + 3]  = objChg[i] & (objStable[2*i +: 2] == 2'b00);
      raw[44 + 11*i + 4]  = openOut[i] & ~openPrev_ff[i];
      raw[44 + 11*i + 5]  = ~openOut[i] & openPrev_ff[i];
      raw[44 + 11*i + 6]  = closeOut[i] & ~closePrev_ff[i];
      raw[44 + 11*i + 7]  = ~closeOut[i] & closePrev_ff[i];
      raw[44 + 11*i + 8]  = objActReq[i] & objBlock[i];
      raw[44 + 11*i + 9]  = ~pulseOn[i] & pulseWas[i] &
                            (objStatus[2*i +: 2] == statAtPulse_ff[2*i +: 2]);
      raw[44 + 11*i + 10] = objNoSelect[i];
    end
    for (i = 0; i < 10; i = i + 1) begin
      raw[121 + 11*i + 0] = inChg[i] & inStable[i];
      raw[121 + 11*i + 1] = inChg[i] & ~inStable[i];
      raw[121 + 11*i + 2] = sigOutLevel[i] & ~sigPrev_ff[i];
      raw[121 + 11*i + 3] = ~sigOutLevel[i] & sigPrev_ff[i];
    end
  end

  // Mask and disable qualification.
  reg [NS-1:0] qual;
  always @* begin
    qual = {NS{1'b0}};
    for (i = 0; i < 4; i = i + 1) begin
      qual[11*i +: 11] = raw[11*i +: 11] & mask_ff[i];
    end
    for (i = 1; i < 18; i = i + 1) begin
      qual[33 + 11*i +: 11] = raw[33 + 11*i +: 11] & mask_ff[i+3] & {11{~dis_ff[i]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending events, lowest slot picked first.
  reg [NS-1:0] pend_ff;
  reg [NS-1:0] pick;
  reg          anyPend;
  reg [7:0]    pickIdx;
  always @* begin
    pick    = {NS{1'b0}};
    anyPend = 1'b0;
    pickIdx = 8'h00;
    for (i = NS - 1; i >= 0; i = i - 1) begin
      if (pend_ff[i]) begin
        anyPend = 1'b1;
        pickIdx = i[7:0];
      end
    end
    if (anyPend) pick[pickIdx] = 1'b1;
  end

  // Channel and code of the picked slot.
  reg [4:0] pickChan;
  reg [5:0] pickCode;
  reg [7:0] rel;
  reg [7:0] chan8;
  reg [7:0] code8;
  always @* begin
    rel   = 8'h00;
    chan8 = 8'h00;
    code8 = pickIdx - pickIdx / 8'd11 + 8'd1;
    if (pickIdx >= 8'd44) begin
      rel   = pickIdx - 8'd44;
      chan8 = rel / 8'd11 + 8'd1;
      code8 = rel % 8'd11 + 8'd1;
    end
    pickChan = chan8[4:0];
    pickCode = code8[5:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Event register: circular store of records.
  reg [26:0] mem [0:DEPTH-1];
  reg [6:0]  wrPtr_ff;
  reg [6:0]  rdPtr_ff;
  reg [6:0]  count_ff;
  reg        ovf_ff;
  wire       full = (count_ff == DEPTH);
  wire       pop  = evtRead & evtValid_ff;
  wire       pushOvf = ovf_ff & ~full;
  wire       pushEvt = anyPend & ~full & ~ovf_ff;
  wire       push    = pushOvf | pushEvt;
  wire [26:0] rec = pushOvf ? {timeMs_ff, 5'd0, `CODE_OVERFLOW} : {timeMs_ff, pickChan, pickCode};

  // Set of a new event wins over the clear of a stored one.
  always @(posedge core_clk) begin
    if (reset) begin
      pend_ff  <= {NS{1'b0}};
      wrPtr_ff <= 7'h00;
      rdPtr_ff <= 7'h00;
      count_ff <= 7'h00;
      ovf_ff   <= 1'b0;
    end else begin
      pend_ff <= (pend_ff & ~((pushEvt | full) ? pick : {NS{1'b0}})) | qual;
      if (anyPend & full) ovf_ff <= 1'b1;
      else if (pushOvf) ovf_ff <= 1'b0;
      if (push) begin
        mem[wrPtr_ff] <= rec;
        wrPtr_ff      <= (wrPtr_ff == DEPTH - 1) ? 7'h00 : wrPtr_ff + 7'h01;
      end
      if (pop) rdPtr_ff <= (rdPtr_ff == DEPTH - 1) ? 7'h00 : rdPtr_ff + 7'h01;
      count_ff <= count_ff + {6'h00, push} - {6'h00, pop};
    end
  end

  // Head record is presented from flops; a pop hides it for one cycle.
  always @(posedge core_clk) begin
    if (reset) begin
      evtValid_ff <= 1'b0;
      evtTime_ff  <= 16'h0000;
      evtChan_ff  <= 5'h00;
      evtCode_ff  <= 6'h00;
    end else begin
      evtValid_ff <= (count_ff != 7'h00) & ~pop;
      {evtTime_ff, evtChan_ff, evtCode_ff} <= mem[rdPtr_ff];
    end
  end
endmodule
`default_nettype wire

/* verif/event_mask_reporting_assertions.sv */
/*
  Port checker for the event reporting block: read port, settings, reclose.
  Assumes the bind at the foot of this file and the shared constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_report_regs.vh"
module event_mask_reporting_checker (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset,
  // Setting port.
  input wire logic        paramWrite,
  input wire logic        paramRead,
  input wire logic [2:0]  paramKind,
  input wire logic [4:0]  paramChan,
  input wire logic [15:0] paramData,
  input wire logic [15:0] paramRdData_ff,
  // Event read port and reclose state.
  input wire logic        evtRead,
  input wire logic        evtValid_ff,
  input wire logic [15:0] evtTime_ff,
  input wire logic [4:0]  evtChan_ff,
  input wire logic [5:0]  evtCode_ff,
  input wire logic        arEnable_ff,
  input wire logic [14:0] arCycleInit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // The head record stands whole until the reader pops it.
  property p_head_stands;
    evtValid_ff && !evtRead |=> evtValid_ff && $stable({evtTime_ff, evtChan_ff, evtCode_ff});
  endproperty
  a_head_stands: assert property (p_head_stands) else $error("head record moved");
  property p_pop_clears;
    evtValid_ff && evtRead |=> !evtValid_ff;
  endproperty
  a_pop_clears: assert property (p_pop_clears) else $error("popped record kept");
  property p_chan_range;
    evtValid_ff |-> evtChan_ff <= 5'h11;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel out of range");
  property p_code_range;
    evtValid_ff |-> evtCode_ff inside {[6'h01:6'h36]};
  endproperty
  a_code_range: assert property (p_code_range) else $error("code out of range");
  property p_time_range;
    evtValid_ff |-> evtTime_ff < `TS_WRAP_MS;
  endproperty
  a_time_range: assert property (p_time_range) else $error("timestamp too large");
  // Reclose is off after reset and comes on with a write of one.
  property p_ar_reset;
    $fell(reset) |-> !arEnable_ff && arCycleInit == 15'h0000;
  endproperty
  a_ar_reset: assert property (p_ar_reset) else $error("reclose on after reset");
  property p_ar_on;
    paramWrite && paramKind == `KIND_AR_ENABLE && paramData == 16'h0001 |=> arEnable_ff;
  endproperty
  a_ar_on: assert property (p_ar_on) else $error("reclose not enabled");
  property p_in_mask_width;
    paramRead && paramKind == `KIND_MASK && paramChan inside {[8:17]}
      |=> paramRdData_ff[15:4] == 12'h000;
  endproperty
  a_in_mask_width: assert property (p_in_mask_width) else $error("input mask too wide");
endmodule
bind event_mask_reporting event_mask_reporting_checker chk_u (
  .core_clk(core_clk), .reset(reset), .paramWrite(paramWrite), .paramRead(paramRead),
  .paramKind(paramKind), .paramChan(paramChan), .paramData(paramData),
  .paramRdData_ff(paramRdData_ff), .evtRead(evtRead), .evtValid_ff(evtValid_ff),
  .evtTime_ff(evtTime_ff), .evtChan_ff(evtChan_ff), .evtCode_ff(evtCode_ff),
  .arEnable_ff(arEnable_ff), .arCycleInit(arCycleInit));
`default_nettype wire

/* verif/event_reader_model.sv */
/*
  Model of the station reader that polls the event register.
  Assumes the block's registered head record and a stall input from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module event_reader_model (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Holds polling back while high.
  input  wire logic        stall,
  // Head record and pop strobe.
  input  wire logic        evtValid_ff,
  input  wire logic [15:0] evtTime_ff,
  input  wire logic [4:0]  evtChan_ff,
  input  wire logic [5:0]  evtCode_ff,
  output logic             evtRead
);
  logic [26:0] recQ[$];
  int          holdoff;
  // Takes one record per pop and waits for the head to refresh before the next.
  initial begin
    evtRead = 1'b0;
    holdoff = 0;
    forever begin
      @(posedge core_clk);
      #1;
      evtRead = 1'b0;
      if (holdoff > 0) begin
        holdoff--;
      end else if (!reset && !stall && evtValid_ff === 1'b1) begin
        recQ.push_back({evtTime_ff, evtChan_ff, evtCode_ff});
        evtRead = 1'b1;
        holdoff = 3;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/event_mask_reporting_test.sv */
/*
  Self-checking bench for the event reporting block: settings, masks,
  filters, overflow and reclose configuration.
  Assumes the design, the reader model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_report_regs.vh"
module event_mask_reporting_test;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        paramWrite = 1'b0;
  logic        paramRead = 1'b0;
  logic [2:0]  paramKind = 3'h0;
  logic [4:0]  paramChan = 5'h00;
  logic [3:0]  paramIdx = 4'h0;
  logic [15:0] paramData = 16'h0000;
  logic [13:0] objStatus = 14'h0000, blkReq = 14'h0000;
  logic [6:0]  openOut = 7'h00;
  logic [9:0]  inputLevel = 10'h000;
  logic [9:0]  ch0GenEvt = 10'h000;
  logic [30:0] ch0CycEvt = 31'h0000_0000;
  logic        stall = 1'b0;
  logic        evtRead, evtValid_ff, arEnable_ff;
  logic [15:0] paramRdData_ff, evtTime_ff, reclaim_ff, d, t1, t2;
  logic [4:0]  evtChan_ff;
  logic [5:0]  evtCode_ff;
  logic [14:0] arCycleInit;
  logic [79:0] arDeadFlat;
  logic [159:0] arStartFlat;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycCount = 0;
  int          i, w;
  int          rstChan[6] = '{0, 0, 0, 0, 1, 8};
  int          rstIdx[6] = '{0, 1, 2, 3, 0, 0};
  logic [15:0] rstVal[6] = '{16'h0043, 16'h0063, 16'h0063, 16'h0703, 16'h0753, 16'h0003};
  int          clpChan[4] = '{0, 0, 2, 8};
  int          clpIdx[4] = '{0, 3, 0, 0};
  logic [15:0] clpVal[4] = '{16'h03FF, 16'h07FF, 16'h07FF, 16'h000F};
  logic [15:0] clpRst[4] = '{16'h0043, 16'h0703, 16'h0753, 16'h0003};

  // Block under test; the short millisecond count keeps filter runs brief.
  event_mask_reporting #(.CLK_PER_MS(5)) dut_u (
    .core_clk(core_clk), .reset(reset), .paramWrite(paramWrite), .paramRead(paramRead),
    .paramKind(paramKind), .paramChan(paramChan), .paramIdx(paramIdx),
    .paramData(paramData), .paramRdData_ff(paramRdData_ff), .objStatus(objStatus),
    .openOut(openOut), .closeOut(7'h00), .objActReq(blkReq[6:0]), .objBlock(blkReq[13:7]),
    .objNoSelect(7'h00), .inputLevel(inputLevel), .sigOutLevel(10'h000),
    .ch0GenEvt(ch0GenEvt), .ch0CycEvt(ch0CycEvt), .evtRead(evtRead),
    .evtValid_ff(evtValid_ff), .evtTime_ff(evtTime_ff), .evtChan_ff(evtChan_ff),
    .evtCode_ff(evtCode_ff), .arEnable_ff(arEnable_ff), .arCycleInit(arCycleInit),
    .arStartFlat(arStartFlat), .arDeadFlat(arDeadFlat), .reclaim_ff(reclaim_ff));
  // Station reader on the event port.
  event_reader_model rdr_u (
    .core_clk(core_clk), .reset(reset), .stall(stall), .evtValid_ff(evtValid_ff),
    .evtTime_ff(evtTime_ff), .evtChan_ff(evtChan_ff), .evtCode_ff(evtCode_ff),
    .evtRead(evtRead));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling that cuts a hang short.
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycCount <= cycCount + 1;
    if (cycCount == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Counts a comparison and reports a difference.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One setting write or read; read data is taken once it has settled.
  task automatic access(input logic wr, input logic [2:0] k, input int c, input int x,
                        input logic [15:0] dIn, output logic [15:0] dOut);
    paramKind = k;
    paramChan = c[4:0];
    paramIdx = x[3:0];
    paramData = dIn;
    paramWrite = wr;
    paramRead = !wr;
    idle(1);
    paramWrite = 1'b0;
    paramRead = 1'b0;
    idle(1);
    dOut = paramRdData_ff;
  endtask
  // Waits for the reader's next record and compares channel and code.
  task automatic take(input logic [4:0] ch, input logic [5:0] cd, output logic [15:0] t);
    logic [26:0] r;
    int          k;
    k = 0;
    while (rdr_u.recQ.size() == 0 && k < 400) begin
      idle(1);
      k++;
    end
    r = (rdr_u.recQ.size() > 0) ? rdr_u.recQ.pop_front() : 27'h7FF_FFFF;
    check("evtChan", r[10:6], ch);
    check("evtCode", r[5:0], cd);
    t = r[26:11];
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    idle(16);
    reset = 1'b0;
    for (i = 0; i < 6; i++) begin
      access(1'b0, `KIND_MASK, rstChan[i], rstIdx[i], 16'h0000, d);
      check("maskReset", d, rstVal[i]);
    end
    access(1'b0, `KIND_DISABLE, 1, 0, 16'h0000, d);
    check("disableReset", d, 16'h0000);
    check("arEnableReset", arEnable_ff, 1'b0);
    // Oversized masks are clipped to the word width, then defaults go back.
    for (i = 0; i < 4; i++) begin
      access(1'b1, `KIND_MASK, clpChan[i], clpIdx[i], 16'hFFFF, d);
      access(1'b0, `KIND_MASK, clpChan[i], clpIdx[i], 16'h0000, d);
      check("maskClip", d, clpVal[i]);
      access(1'b1, `KIND_MASK, clpChan[i], clpIdx[i], clpRst[i], d);
    end
    // Every channel 0 event once; only weights in the default masks appear.
    for (i = 1; i <= 41; i++) begin
      if (i <= 10) ch0GenEvt[i-1] = 1'b1;
      else ch0CycEvt[i-11] = 1'b1;
      idle(1);
      ch0GenEvt = 10'h000;
      ch0CycEvt = 31'h0000_0000;
      w = (i > 30) ? 3 : (i - 1) / 10;
      if (rstVal[w][i-1-10*w]) take(5'h00, i[5:0], t1);
      idle(3);
    end
    idle(20);
    check("maskedQuiet", rdr_u.recQ.size(), 0);
    // Input channel 8: a short glitch is dropped, held levels are delayed.
    access(1'b1, `KIND_DELAY, 8, 0, 16'h0002, d);
    access(1'b1, `KIND_DELAY, 8, 1, 16'h0006, d);
    inputLevel[0] = 1'b1;
    idle(3);
    inputLevel[0] = 1'b0;
    idle(60);
    check("glitchDropped", rdr_u.recQ.size(), 0);
    inputLevel[0] = 1'b1;
    idle(100);
    inputLevel[0] = 1'b0;
    take(5'h08, 6'h01, t1);
    take(5'h08, 6'h02, t2);
    check("delayedGap", (t2 - t1 >= 16'h0017) && (t2 - t1 <= 16'h0019), 1'b1);
    access(1'b1, `KIND_DISABLE, 8, 0, 16'h0001, d);
    inputLevel[0] = 1'b1;
    idle(60);
    inputLevel[0] = 1'b0;
    idle(60);
    check("disabledQuiet", rdr_u.recQ.size(), 0);
    access(1'b1, `KIND_DISABLE, 8, 0, 16'h0000, d);
    // Object channel 1: status changes, then an open pulse that moves nothing.
    for (i = 0; i < 4; i++) access(1'b1, `KIND_DELAY, 1, i, 16'h0001, d);
    objStatus[1:0] = 2'b10;
    take(5'h01, 6'h01, t1);
    objStatus[1:0] = 2'b01;
    take(5'h01, 6'h02, t1);
    openOut[0] = 1'b1;
    take(5'h01, 6'h05, t1);
    openOut[0] = 1'b0;
    take(5'h01, 6'h0A, t1);
    blkReq = 14'h0081;
    idle(1);
    blkReq = 14'h0000;
    take(5'h01, 6'h09, t1);
    // Reader stalls while 110 events arrive; 100 are kept, then overflow.
    stall = 1'b1;
    for (i = 0; i < 110; i++) begin
      ch0GenEvt[0] = 1'b1;
      idle(1);
      ch0GenEvt[0] = 1'b0;
      idle(1);
    end
    idle(10);
    stall = 1'b0;
    for (i = 0; i < 100; i++) take(5'h00, 6'h01, t1);
    take(5'h00, 6'h33, t1);
    // Reclose enable, cycle selection, dead and reclaim times.
    access(1'b1, `KIND_AR_ENABLE, 0, 0, 16'h0001, d);
    check("arEnable", arEnable_ff, 1'b1);
    check("arInit", arCycleInit, `AR_SEL_DEFAULT);
    access(1'b1, `KIND_AR_SEL, 1, 1, 16'h0000, d);
    access(1'b1, `KIND_AR_SEL, 1, 0, 16'h0001, d);
    check("arSel", arCycleInit, 15'h002E);
    access(1'b1, `KIND_AR_DEAD, 1, 0, 16'h012C, d);
    access(1'b1, `KIND_RECLAIM, 0, 0, 16'h1388, d);
    check("arDead", arDeadFlat[16 +: 16], 16'h012C);
    check("reclaim", reclaim_ff, 16'h1388);
    access(1'b1, `KIND_AR_START, 1, 1, 16'h0032, d);
    check("arStart", arStartFlat[63:48], 16'h0032);
    access(1'b1, `KIND_AR_ENABLE, 0, 0, 16'h0000, d);
    check("arDisable", arEnable_ff, 1'b0);
    idle(20);
    check("finalQuiet", rdr_u.recQ.size(), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
